/* File: hdl/cal_reference_key_registers.sv */
// APB register group: access key plus four per-loop calibration level registers.
// Assumes an APB master on pclk; one wait state on every transfer.
`timescale 1ns/1ps
`include "cal_ref_cfg.svh"
module cal_reference_key_registers (
   input  wire logic                   pclk,
   input  wire logic                   presetn,
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire cal_ref_pkg::apb_addr_t paddr,
   input  wire logic [31:0]            pwdata,
   input  wire logic [3:0]             pstrb,
   output logic [31:0]                 prdata,
   output logic                        pready,
   output logic                        pslverr,
   output cal_ref_pkg::vsel_bus_t      calibration_reference_voltage,
   output cal_ref_pkg::loop_mask_t     cal_override_enable,
   output logic                        cal_unlocked
);
   import cal_ref_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // Address decoding helpers

   function automatic logic is_level(input reg_idx_t idx);
      is_level = (idx == `LEVEL0_IDX) || (idx == `LEVEL1_IDX)
              || (idx == `LEVEL2_IDX) || (idx == `LEVEL3_IDX);
   endfunction

   function automatic loop_idx_t loop_of(input reg_idx_t idx);
      loop_idx_t sel;
      sel = 2'h0;
      if (idx == `LEVEL1_IDX) begin
         sel = 2'h1;
      end else if (idx == `LEVEL2_IDX) begin
         sel = 2'h2;
      end else if (idx == `LEVEL3_IDX) begin
         sel = 2'h3;
      end
      loop_of = sel;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // State

   logic [`KEY_W-1:0] access_key;
   logic              write_rejected;
   apb_phase_t        phase;

   cal_level_if lv ();

   cal_level_bank cal_level_bank_inst (
      .pclk    (pclk),
      .presetn (presetn),
      .lv      (lv.bank)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Decode

   wire reg_idx_t  idx         = paddr[`IDX_MSB:`IDX_LSB];
   wire logic      hit_key     = (idx == `KEY_IDX);
   wire logic      hit_status  = (idx == `STATUS_IDX);
   wire logic      hit_level   = is_level(idx);
   wire logic      mapped      = hit_key | hit_status | hit_level;
   wire loop_idx_t slot        = loop_of(idx);
   wire logic      lane0       = pstrb[0];

   // Completing edge: access phase with pready already high
   wire logic      complete    = (phase == RESPOND) & psel & penable;
   wire logic      wr_done     = complete & pwrite & lane0;
   wire logic      unlocked    = (access_key == `UNLOCK_VALUE);          // RULE2

   ////////////////////////////////////////////////////////////////////////////////
   // Bus phase

   wire apb_phase_t next_phase = (phase == IDLE && psel && penable) ? RESPOND : IDLE;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase  <= IDLE;
         pready <= 1'b0;
      end else begin
         phase  <= next_phase;
         pready <= (next_phase == RESPOND);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Access key

   wire logic              key_wr   = wr_done & hit_key;
   wire logic [`KEY_W-1:0] next_key = key_wr ? pwdata[`KEY_W-1:0] : access_key;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         access_key   <= `KEY_RESET;                                   // RULE2
         cal_unlocked <= 1'b0;
      end else begin
         access_key   <= next_key;
         cal_unlocked <= (next_key == `UNLOCK_VALUE);                  // RULE1
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Level writes; locked writes are dropped, storage untouched

   assign lv.wr_stb               = wr_done & hit_level & unlocked;    // RULE1 RULE12
   assign lv.wr_idx               = slot;                              // RULE4
   assign lv.wr_level.vsel        = pwdata[`VSEL_MSB:`VSEL_LSB];       // RULE5
   assign lv.wr_level.override_en = pwdata[`OVR_BIT];                  // RULE7

   // Sticky record of a dropped write; a new drop beats a clear
   wire logic reject_set     = wr_done & hit_level & ~unlocked;        // RULE12
   wire logic reject_clr     = wr_done & hit_status & pwdata[`STAT_REJECT_BIT];
   wire logic next_rejected  = reject_set | (write_rejected & ~reject_clr);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         write_rejected <= 1'b0;
      end else begin
         write_rejected <= next_rejected;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Loop outputs, registered from the storage

   vsel_bus_t  next_vsel_bus;
   loop_mask_t next_ovr_mask;

   always_comb begin
      next_vsel_bus = '0;
      next_ovr_mask = '0;
      for (int i = 0; i < `NUM_LOOPS; i++) begin
         next_vsel_bus[2*i +: 2] = lv.levels[i].vsel;
         next_ovr_mask[i]        = lv.levels[i].override_en;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         calibration_reference_voltage <= '0;
         cal_override_enable           <= '0;
      end else begin
         calibration_reference_voltage <= next_vsel_bus;
         cal_override_enable           <= next_ovr_mask;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Read data; reserved bits read zero

   wire level_t      rd_level   = lv.levels[slot];
   wire logic [31:0] key_word   = {24'h0, access_key};
   wire logic [31:0] stat_word  = {30'h0, write_rejected, unlocked};
   wire logic [31:0] level_word = {29'h0, rd_level.vsel, rd_level.override_en};
   wire logic [31:0] next_prdata =
      (!pwrite && hit_key)    ? key_word   :
      (!pwrite && hit_status) ? stat_word  :
      (!pwrite && hit_level)  ? level_word : 32'h0;

   // Captured on entering the answer cycle; nothing else can change state meanwhile
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0;
         pslverr <= 1'b0;
      end else if (next_phase == RESPOND) begin
         prdata  <= next_prdata;
         pslverr <= ~mapped;
      end else begin
         prdata  <= 32'h0;
         pslverr <= 1'b0;
      end
   end
endmodule

/* File: include/cal_ref_cfg.svh */
// Constants of the calibration reference key register group.
// Assumes register indices are word indices on an APB bus (byte address = 4 * index).
//
// Function
// (RULE1) Level registers accept writes only while the key holds the unlock value.
// (RULE2) Key resets to zero; any other value than unlock keeps levels locked.
// (RULE3) Software returns the key to zero after programming the levels.
// (RULE4) Key governs four level registers, one per analog loop, at fixed addresses.
// (RULE5) Level select sits in bits two to one, codes zero to three, reset zero.
// (RULE6) Software programs each level select to reference voltage one.
// (RULE7) Bit zero enables manual override per loop, reset zero meaning disabled.
// (RULE8) Software sets the override enable bit for each loop.
// (RULE9) Software commits levels with the transfer strobe before calibration.
// (RULE10) Software programs the level fields only once per power cycle.
// (RULE11) Software writes the unlock value before any level register write.
// (RULE12) While locked, level register writes are ignored and contents kept.
`ifndef CAL_REF_CFG_SVH
`define CAL_REF_CFG_SVH

`define NUM_LOOPS        4
`define ADDR_W           16
`define IDX_W            14
`define IDX_LSB          2
`define IDX_MSB          15

`define KEY_IDX          14'h0fff
`define STATUS_IDX       14'h0ffe
`define LEVEL0_IDX       14'h1488
`define LEVEL1_IDX       14'h1588
`define LEVEL2_IDX       14'h1688
`define LEVEL3_IDX       14'h1788

`define UNLOCK_VALUE     8'hf9
`define KEY_RESET        8'h00
`define VSEL_RESET       2'h0
`define OVR_RESET        1'b0
`define KEY_W            8

`define VSEL_LSB         1
`define VSEL_MSB         2
`define OVR_BIT          0
`define STAT_UNLOCK_BIT  0
`define STAT_REJECT_BIT  1

`endif

/* File: include/cal_ref_pkg.sv */
// Types of the calibration reference key register group.
// Assumes cal_ref_cfg.svh for widths.
`include "cal_ref_cfg.svh"
package cal_ref_pkg;
   typedef logic [1:0]                 voltage_select_t;
   typedef logic [1:0]                 loop_idx_t;
   typedef logic [2*`NUM_LOOPS-1:0]    vsel_bus_t;
   typedef logic [`NUM_LOOPS-1:0]      loop_mask_t;
   typedef logic [`ADDR_W-1:0]         apb_addr_t;
   typedef logic [`IDX_W-1:0]          reg_idx_t;
   typedef struct packed {
      voltage_select_t vsel;
      logic            override_en;
   } level_t;
   typedef enum logic {IDLE, RESPOND} apb_phase_t;
endpackage

/* File: include/cal_level_if.sv */
// Write port and read-back of the per-loop calibration level storage.
// Assumes the register front end is the only writer.
`timescale 1ns/1ps
`include "cal_ref_cfg.svh"
interface cal_level_if;
   import cal_ref_pkg::*;
   logic      wr_stb;
   loop_idx_t wr_idx;
   level_t    wr_level;
   level_t    levels [`NUM_LOOPS];
   modport bank (input wr_stb, input wr_idx, input wr_level, output levels);
   modport regs (output wr_stb, output wr_idx, output wr_level, input levels);
endinterface

/* File: hdl/cal_level_bank.sv */
// Flip-flop storage of the four calibration level entries.
// Assumes write strobes arrive already qualified by the access key.
`timescale 1ns/1ps
`include "cal_ref_cfg.svh"
module cal_level_bank (
   input wire logic        pclk,
   input wire logic        presetn,
   cal_level_if.bank       lv
);
   import cal_ref_pkg::*;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < `NUM_LOOPS; i++) begin
            lv.levels[i].vsel        <= `VSEL_RESET;  // RULE5
            lv.levels[i].override_en <= `OVR_RESET;   // RULE7
         end
      end else if (lv.wr_stb) begin
         lv.levels[lv.wr_idx] <= lv.wr_level;         // RULE4
      end
   end
endmodule

/* File: verif/cal_reference_key_registers_sva.sv */
// Checker of the key register group, seen from the APB and loop ports only.
// Assumes one clock, pclk, and the asynchronous active-low presetn.
`timescale 1ns/1ps
`include "cal_ref_cfg.svh"
module cal_reference_key_registers_sva
   import cal_ref_pkg::*;
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire apb_addr_t   paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0]  pstrb,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire vsel_bus_t   calibration_reference_voltage,
   input wire loop_mask_t  cal_override_enable,
   input wire logic        cal_unlocked
);
default clocking @(posedge pclk); endclocking
default disable iff (!presetn);
wire       wr_take = psel && penable && pready && pwrite && pstrb[0];
wire [13:0] idx    = paddr[15:2];
wire       lvl_hit = idx == `LEVEL0_IDX || idx == `LEVEL1_IDX
                     || idx == `LEVEL2_IDX || idx == `LEVEL3_IDX;
wire       mapped  = lvl_hit || idx == `KEY_IDX || idx == `STATUS_IDX;
sequence key_wr;
   wr_take && idx == `KEY_IDX;
endsequence
sequence lvl0_wr;
   wr_take && idx == `LEVEL0_IDX && cal_unlocked;
endsequence
////////////////////////////////////////////////////////////////////////////////
pready_pulse_a: assert property (pready |=> !pready) else $error("pready too long");
wait_state_a: assert property (psel && !penable |=> !pready ##1 pready)
   else $error("wait state wrong");
unlock_track_a: assert property (key_wr |-> ##2
   cal_unlocked == ($past(pwdata[7:0], 2) == `UNLOCK_VALUE)) else $error("unlock wrong");
locked_keep_a: assert property (wr_take && lvl_hit && !cal_unlocked |=>
   ($stable(calibration_reference_voltage) && $stable(cal_override_enable))[*3])
   else $error("locked write took effect");
level_store_a: assert property (lvl0_wr |-> ##2
   calibration_reference_voltage[1:0] == $past(pwdata[2:1], 2)
   && cal_override_enable[0] == $past(pwdata[0], 2)) else $error("level not stored");
unmapped_err_a: assert property (pready |-> pslverr == !mapped) else $error("pslverr wrong");
idle_rdata_a: assert property (!pready |-> prdata == 32'h0) else $error("prdata not zero");
status_key_a: assert property (pready && !pwrite && idx == `STATUS_IDX
   |-> prdata[0] == cal_unlocked) else $error("status bit wrong");
endmodule
bind cal_reference_key_registers cal_reference_key_registers_sva
   cal_reference_key_registers_sva_inst (.pclk, .presetn, .psel, .penable, .pwrite,
   .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .calibration_reference_voltage,
   .cal_override_enable, .cal_unlocked);

/* File: verif/cal_reference_key_registers_bench.sv */
// Self-checking bench of the key register group over APB.
// Assumes the checker is bound from its own file.
`timescale 1ns/1ps
`include "cal_ref_cfg.svh"
module cal_reference_key_registers_bench;
import cal_ref_pkg::*;
logic        pclk    = 0;
logic        presetn = 0;
logic        psel    = 0;
logic        penable = 0;
logic        pwrite  = 0;
apb_addr_t   paddr   = '0;
logic [31:0] pwdata  = '0;
logic [3:0]  pstrb   = 4'hf;
logic [31:0] prdata;
logic        pready;
logic        pslverr;
logic        cal_unlocked;
vsel_bus_t   calibration_reference_voltage;
loop_mask_t  cal_override_enable;
int          fails = 0;
int          check_count = 0;
int          cyc = 0;
localparam apb_addr_t KEY_A = {`KEY_IDX, 2'b00};
localparam apb_addr_t STAT_A = {`STATUS_IDX, 2'b00};
always #2.5 pclk = ~pclk;
cal_reference_key_registers cal_reference_key_registers_inst (.pclk, .presetn, .psel,
   .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
   .calibration_reference_voltage, .cal_override_enable, .cal_unlocked);
////////////////////////////////////////////////////////////////////////////////
task automatic summarize;
   $display("checks %0d mismatches %0d", check_count, fails);
   if (fails == 0 && check_count > 0) $display("Finished cleanly");
   else $display("Finished with errors");
   $finish;
endtask
always @(posedge pclk) begin
   cyc <= cyc + 1;
   if (cyc == 5000) begin
      fails++;
      summarize;
   end
end
task automatic chk(input logic [31:0] got, input logic [31:0] exp);
   check_count++;
   if (got !== exp) begin
      fails++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
   end
endtask
// Idle edge first, so a release and the next setup never share a time step
task automatic apb(input logic w, input apb_addr_t a, input logic [31:0] d,
                   output logic [31:0] r, output logic e);
   @(posedge pclk);
   psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
   @(posedge pclk);
   penable <= 1;
   do @(posedge pclk); while (pready !== 1'b1);
   r = prdata;
   e = pslverr;
   psel <= 0; penable <= 0;
endtask
task automatic wr(input apb_addr_t a, input logic [31:0] d);
   logic [31:0] r;
   logic e;
   apb(1, a, d, r, e);
   chk(e, 0);
endtask
task automatic rd(input apb_addr_t a, input logic [31:0] exp);
   logic [31:0] r;
   logic e;
   apb(0, a, 0, r, e);
   chk(r, exp);
   chk(e, 0);
endtask
function automatic apb_addr_t lvl(input int i);
   return {14'(`LEVEL0_IDX + 14'h100 * i), 2'b00};
endfunction
task automatic settle;
   repeat (3) @(posedge pclk);
   #1;
endtask
////////////////////////////////////////////////////////////////////////////////
task automatic t_reset;
   rd(KEY_A, 0);
   for (int i = 0; i < 4; i++) rd(lvl(i), 0);
   chk({cal_unlocked, calibration_reference_voltage, cal_override_enable}, 0);
   $display("test reset done");
endtask
task automatic t_locked;
   wr(KEY_A, 32'h55);
   wr(lvl(0), 32'h07);
   settle;
   chk(cal_unlocked, 0);
   rd(lvl(0), 0);
   rd(STAT_A, 2);
   wr(STAT_A, 2);
   rd(STAT_A, 0);
   $display("test locked done");
endtask
task automatic t_program;
   wr(KEY_A, 32'hf9);
   settle;
   chk(cal_unlocked, 1);
   rd(STAT_A, 1);
   // Reserved bits set too; loop i gets code i, override on even loops
   for (int i = 0; i < 4; i++) wr(lvl(i), 32'hf8 | (i << 1) | (~i & 1));
   // Low byte lane off: write must be dropped, readback below proves it
   pstrb <= 4'he;
   wr(lvl(1), 32'h00);
   pstrb <= 4'hf;
   settle;
   chk(calibration_reference_voltage, 8'he4);
   chk(cal_override_enable, 4'h5);
   for (int i = 0; i < 4; i++) rd(lvl(i), (i << 1) | (~i & 1));
   wr(KEY_A, 0);
   wr(lvl(0), 32'h02);
   settle;
   rd(lvl(0), 1);
   chk(calibration_reference_voltage, 8'he4);
   $display("test program done");
endtask
task automatic t_unmapped;
   logic [31:0] r;
   logic e;
   apb(1, 16'h0000, 32'hf9, r, e);
   chk(e, 1);
   apb(0, 16'h0000, 0, r, e);
   chk(r, 0);
   chk(e, 1);
   chk(cal_unlocked, 0);
   $display("test unmapped done");
endtask
// Second power cycle: reset mid-run, then the recommended sequence once
task automatic t_power_cycle;
   logic [31:0] r;
   logic e;
   presetn <= 0;
   repeat (3) @(posedge pclk);
   presetn <= 1;
   #1;
   chk({cal_unlocked, calibration_reference_voltage, cal_override_enable}, 0);
   rd(KEY_A, 0);
   rd(STAT_A, 0);
   wr(KEY_A, 32'hf9);
   for (int i = 0; i < 4; i++) wr(lvl(i), 32'h03);
   // Commit strobe lives outside this block, so it answers as unmapped
   apb(1, {14'h000f, 2'b00}, 32'h01, r, e);
   chk(e, 1);
   wr(KEY_A, 0);
   settle;
   chk(calibration_reference_voltage, 8'h55);
   chk(cal_override_enable, 4'hf);
   chk(cal_unlocked, 0);
   $display("test power cycle done");
endtask
initial begin
   repeat (3) @(posedge pclk);
   presetn <= 1;
   t_reset;
   t_locked;
   t_program;
   t_unmapped;
   t_power_cycle;
   summarize;
end
endmodule
